// File: design/fplc_pkg.sv
// Shared constants and types for the flash program launch controller
package fplc_pkg;
	localparam logic [3:0]  ADDR_CTRL        = 4'h0;
	localparam logic [3:0]  ADDR_AUX         = 4'h4;
	localparam logic [3:0]  ADDR_AUX_ONE     = 4'h8;
	localparam logic [3:0]  ADDR_STATUS      = 4'hc;
	localparam int          CTRL_KEY_LSB     = 4;
	localparam int          CTRL_MAP_BIT     = 3;
	localparam int          CTRL_SPACE_LSB   = 1;
	localparam int          CTRL_BUSY_BIT    = 0;
	localparam int          AUX_XRAM_BIT     = 1;
	localparam int          AUX_ONE_BOOT_BIT = 5;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam logic [3:0]  KEY_ARM          = 4'h5;
	localparam logic [3:0]  KEY_GO           = 4'ha;
	localparam logic [1:0]  SPACE_USER       = 2'h0;
	localparam logic [1:0]  SPACE_EXTRA      = 2'h1;
	localparam logic [1:0]  SPACE_SECURITY   = 2'h2;
	localparam logic [1:0]  SPACE_RESERVED   = 2'h3;
	localparam logic [15:0] EXTRA_ROW_BASE   = 16'hff80;
	localparam logic [15:0] BOOT_BASE        = 16'hf800;
	localparam logic [7:0]  ERASED_BYTE      = 8'hff;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_DECERR      = 2'h3;
	localparam int          CLK_PERIOD_NS    = 8;
	localparam int          PROG_TIME_NS     = 10000000;
	localparam int          PROG_CYCLES      = PROG_TIME_NS / CLK_PERIOD_NS;

	typedef struct packed
	{
		logic [3:0] launch_key;
		logic       latch_map_select;
		logic [1:0] space_select;
		logic       program_in_progress;
	} fplc_ctrl_s;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_ERASE = 2'b01,
		ST_PROG  = 2'b10,
		ST_HOLD  = 2'b11
	} fplc_state_e;
endpackage

// File: design/fplc_flash_program_launch_ctrl.sv
// Flash program launch controller: column latches, key launch, erase/program sequencer
//
// Function
// RQ1: Latch map steers program-range data writes
// RQ2: Bits 6..0 byte offset, 14..7 page
// RQ3: Latch map overrides external RAM select
// RQ4: User flash otherwise read-only via code reads
// RQ5: Space select picks code-read target
// RQ6: Launch only on key 5 then A
// RQ7: Space select picks programmed space; 11 none
// RQ8: Busy flash serves no instruction fetches
// RQ9: CPU held idle until programming completes
// RQ10: Busy bit reads one while programming
// RQ11: Software disables interrupts around programming
// RQ12: Boot-map bit selects boot array at top
// RQ13: Latches accept one to 128 bytes
// RQ14: Erase then program only loaded bytes
// RQ15: Software loads latches by data writes
// RQ16: Last latch page sets programmed page
// RQ17: User space launch is 50h, A0h
// RQ18: Extra row launch is 52h, A2h
// RQ19: Security byte: 0Ch, write 0000h, 54h, A4h
// RQ20: Code-read map 00h, 02h, 04h
// RQ21: Control register bit layout
// RQ22: Software cannot clear busy bit
// RQ23: Control register resets to zero
// RQ24: Boot map covers F800h to FFFFh
// RQ25: Lone second key resets key sequence
`timescale 1ns/1ps
`default_nettype none
module fplc_flash_program_launch_ctrl
#(
	parameter int PROG_CYCLES = fplc_pkg::PROG_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [3:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        dwr_valid,
	input  wire logic [15:0] dwr_addr,
	input  wire logic [7:0]  dwr_data,
	output logic             int_ram_wr,
	output logic             ext_ram_wr,
	output logic [15:0]      ram_wr_addr,
	output logic [7:0]       ram_wr_data,
	input  wire logic        code_rd_req,
	input  wire logic [15:0] code_rd_addr,
	output logic             code_rd_valid,
	output logic [7:0]       code_rd_data,
	output logic             code_rd_boot,
	output logic             cpu_idle_req,
	output logic             flash_busy
);
	fplc_pkg::fplc_ctrl_s    ctrl_ff;
	fplc_pkg::fplc_state_e   state_ff;
	logic                    xram_sel_ff;
	logic                    boot_map_ff;
	logic                    armed_ff;
	logic [7:0]              page_ff;
	logic [7:0]              latch_data [0:127];
	logic [127:0]            loaded_ff;
	logic [7:0]              main_mem [0:32767];
	logic [7:0]              extra_mem [0:127];
	logic [7:0]              security_ff;
	logic [6:0]              idx_ff;
	logic [1:0]              prog_space_ff;
	logic [20:0]             hold_ff;
	logic                    aw_held_ff;
	logic                    w_held_ff;
	logic [3:0]              aw_addr_ff;
	logic [31:0]             w_data_ff;
	logic                    w_lane0_ff;
	logic                    wr_go;
	logic                    ctrl_wr;
	logic [3:0]              new_key;
	logic [1:0]              new_space;
	logic                    launch;
	logic                    latch_hit;
	logic [14:0]             prog_addr;

	// Write address and data may arrive in either order; both are held
	assign wr_go     = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign ctrl_wr   = wr_go && (aw_addr_ff == fplc_pkg::ADDR_CTRL) && w_lane0_ff;
	assign new_key   = w_data_ff[fplc_pkg::CTRL_KEY_LSB +: 4];
	assign new_space = w_data_ff[fplc_pkg::CTRL_SPACE_LSB +: 2];
	assign launch    = ctrl_wr && armed_ff && (new_key == fplc_pkg::KEY_GO)
		&& (new_space != fplc_pkg::SPACE_RESERVED) && (state_ff == fplc_pkg::ST_IDLE); // RQ6 RQ7
	assign latch_hit = dwr_valid && ctrl_ff.latch_map_select
		&& (!dwr_addr[15] || (dwr_addr >= fplc_pkg::EXTRA_ROW_BASE)); // RQ1 RQ4
	assign prog_addr = {page_ff, idx_ff}; // RQ2 RQ16

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			aw_addr_ff    <= 4'h0;
			w_data_ff     <= 32'h0000_0000;
			w_lane0_ff    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= fplc_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_ff && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held_ff && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff  <= 1'b1;
				w_data_ff  <= s_axi_wdata;
				w_lane0_ff <= s_axi_wstrb[0];
			end
			if (wr_go)
			begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_ff == fplc_pkg::ADDR_STATUS) ? fplc_pkg::RESP_OKAY
					: fplc_pkg::RESP_OKAY;
			end
			else if (s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register; busy bit is not stored here so software cannot touch it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff <= fplc_pkg::CTRL_RESET; // RQ23
		end
		else if (ctrl_wr)
		begin
			ctrl_ff.launch_key       <= new_key; // RQ21
			ctrl_ff.latch_map_select <= w_data_ff[fplc_pkg::CTRL_MAP_BIT];
			ctrl_ff.space_select     <= new_space;
			ctrl_ff.program_in_progress <= 1'b0; // RQ22
		end
	end

	// Key sequence: any control write that is not 5 disarms
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed_ff <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			armed_ff <= (new_key == fplc_pkg::KEY_ARM); // RQ6 RQ25
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			xram_sel_ff <= 1'b0;
			boot_map_ff <= 1'b0;
		end
		else if (wr_go && w_lane0_ff)
		begin
			if (aw_addr_ff == fplc_pkg::ADDR_AUX)
			begin
				xram_sel_ff <= w_data_ff[fplc_pkg::AUX_XRAM_BIT];
			end
			if (aw_addr_ff == fplc_pkg::ADDR_AUX_ONE)
			begin
				boot_map_ff <= w_data_ff[fplc_pkg::AUX_ONE_BOOT_BIT]; // RQ12
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= fplc_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= fplc_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					fplc_pkg::ADDR_CTRL:
						s_axi_rdata <= {24'h000000, ctrl_ff.launch_key, ctrl_ff.latch_map_select,
							ctrl_ff.space_select, state_ff != fplc_pkg::ST_IDLE}; // RQ10 RQ21
					fplc_pkg::ADDR_AUX:
						s_axi_rdata <= {30'h0, xram_sel_ff, 1'b0};
					fplc_pkg::ADDR_AUX_ONE:
						s_axi_rdata <= {26'h0, boot_map_ff, 5'h00};
					fplc_pkg::ADDR_STATUS:
						s_axi_rdata <= {23'h0, armed_ff, page_ff};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= fplc_pkg::RESP_DECERR;
					end
				endcase
			end
			else if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Data-space write routing; latch map wins over the external RAM select
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_ram_wr  <= 1'b0;
			ext_ram_wr  <= 1'b0;
			ram_wr_addr <= 16'h0000;
			ram_wr_data <= 8'h00;
		end
		else
		begin
			int_ram_wr  <= dwr_valid && !latch_hit && !xram_sel_ff; // RQ3
			ext_ram_wr  <= dwr_valid && !latch_hit && xram_sel_ff; // RQ3
			ram_wr_addr <= dwr_addr;
			ram_wr_data <= dwr_data;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (latch_hit)
		begin
			latch_data[dwr_addr[6:0]] <= dwr_data; // RQ2 RQ13 RQ15
		end
	end

	// Loaded flags mark which bytes get erased and programmed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			loaded_ff <= 128'h0;
			page_ff   <= 8'h00;
		end
		else if (state_ff == fplc_pkg::ST_HOLD && hold_ff == 21'h0)
		begin
			loaded_ff <= 128'h0;
		end
		else if (latch_hit && state_ff == fplc_pkg::ST_IDLE)
		begin
			loaded_ff[dwr_addr[6:0]] <= 1'b1; // RQ13
			page_ff                  <= dwr_addr[14:7]; // RQ2 RQ16
		end
	end

	// Sequencer: erase pass, program pass, then the remaining program time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff      <= fplc_pkg::ST_IDLE;
			idx_ff        <= 7'h00;
			prog_space_ff <= fplc_pkg::SPACE_USER;
			hold_ff       <= 21'h0;
		end
		else
		begin
			unique case (state_ff)
				fplc_pkg::ST_IDLE:
					if (launch)
					begin
						state_ff      <= fplc_pkg::ST_ERASE; // RQ8
						prog_space_ff <= new_space; // RQ7
						idx_ff        <= 7'h00;
					end
				fplc_pkg::ST_ERASE:
				begin
					idx_ff <= idx_ff + 7'h01;
					if (idx_ff == 7'h7f)
					begin
						state_ff <= fplc_pkg::ST_PROG; // RQ14
					end
				end
				fplc_pkg::ST_PROG:
				begin
					idx_ff <= idx_ff + 7'h01;
					if (idx_ff == 7'h7f)
					begin
						state_ff <= fplc_pkg::ST_HOLD;
						hold_ff  <= 21'(PROG_CYCLES - 257);
					end
				end
				fplc_pkg::ST_HOLD:
					if (hold_ff == 21'h0)
					begin
						state_ff <= fplc_pkg::ST_IDLE; // RQ9 RQ10
					end
					else
					begin
						hold_ff <= hold_ff - 21'h1;
					end
			endcase
		end
	end

	// Array writes; only loaded offsets are touched
	always_ff @(posedge aclk)
	begin
		if ((state_ff == fplc_pkg::ST_ERASE || state_ff == fplc_pkg::ST_PROG) && loaded_ff[idx_ff])
		begin
			unique case (prog_space_ff)
				fplc_pkg::SPACE_USER:
					main_mem[prog_addr] <= (state_ff == fplc_pkg::ST_ERASE)
						? fplc_pkg::ERASED_BYTE : latch_data[idx_ff]; // RQ14
				fplc_pkg::SPACE_EXTRA:
					extra_mem[idx_ff] <= (state_ff == fplc_pkg::ST_ERASE)
						? fplc_pkg::ERASED_BYTE : latch_data[idx_ff];
				default:
					if (idx_ff == 7'h00)
					begin
						security_ff <= (state_ff == fplc_pkg::ST_ERASE)
							? fplc_pkg::ERASED_BYTE : latch_data[7'h00];
					end
			endcase
		end
	end

	// Code reads: none answered while busy since the array cannot be fetched from
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			code_rd_valid <= 1'b0;
			code_rd_data  <= 8'h00;
			code_rd_boot  <= 1'b0;
		end
		else
		begin
			code_rd_valid <= code_rd_req && state_ff == fplc_pkg::ST_IDLE; // RQ8
			code_rd_boot  <= 1'b0;
			code_rd_data  <= fplc_pkg::ERASED_BYTE;
			unique case (ctrl_ff.space_select) // RQ5
				fplc_pkg::SPACE_USER:
					if (boot_map_ff && code_rd_addr >= fplc_pkg::BOOT_BASE)
					begin
						code_rd_boot <= code_rd_req && state_ff == fplc_pkg::ST_IDLE; // RQ12 RQ24
					end
					else if (!code_rd_addr[15])
					begin
						code_rd_data <= main_mem[code_rd_addr[14:0]];
					end
				fplc_pkg::SPACE_EXTRA:
					if (code_rd_addr >= fplc_pkg::EXTRA_ROW_BASE)
					begin
						code_rd_data <= extra_mem[code_rd_addr[6:0]];
					end
				fplc_pkg::SPACE_SECURITY:
					if (code_rd_addr == 16'h0000)
					begin
						code_rd_data <= security_ff;
					end
				default:
					code_rd_data <= fplc_pkg::ERASED_BYTE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_idle_req <= 1'b0;
			flash_busy   <= 1'b0;
		end
		else
		begin
			cpu_idle_req <= launch || (state_ff != fplc_pkg::ST_IDLE
				&& !(state_ff == fplc_pkg::ST_HOLD && hold_ff == 21'h0)); // RQ9
			flash_busy   <= launch || (state_ff != fplc_pkg::ST_IDLE
				&& !(state_ff == fplc_pkg::ST_HOLD && hold_ff == 21'h0)); // RQ8
		end
	end
endmodule
`default_nettype wire

// File: verif/fplc_flash_program_launch_ctrl_assertions.sv
// Port-level assertions for the flash program launch controller
`timescale 1ns/1ps
`default_nettype none
module fplc_chk
#(
	parameter int PROG_CYCLES = 300
)
(
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	s_axi_bvalid,
	input wire logic	dwr_valid,
	input wire logic [15:0]	dwr_addr,
	input wire logic	int_ram_wr,
	input wire logic	ext_ram_wr,
	input wire logic [15:0]	ram_wr_addr,
	input wire logic	code_rd_req,
	input wire logic [15:0]	code_rd_addr,
	input wire logic	code_rd_valid,
	input wire logic	code_rd_boot,
	input wire logic	cpu_idle_req,
	input wire logic	flash_busy
);
	logic [31:0]	busy_cnt_ff;

	// Counts busy cycles so that a hung sequencer is caught, not only a short one
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !flash_busy)
			busy_cnt_ff <= 32'h0;
		else
			busy_cnt_ff <= busy_cnt_ff + 32'h1;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_fetch_busy; code_rd_req && flash_busy; endsequence
	sequence s_busy_end; flash_busy ##1 !flash_busy; endsequence

	property p_no_fetch; s_fetch_busy |=> !code_rd_valid; endproperty
	a_no_fetch: assert property (p_no_fetch) else $error("fetch served while busy");
	property p_fetch; code_rd_req && !flash_busy |=> code_rd_valid; endproperty
	a_fetch: assert property (p_fetch) else $error("code read not answered");
	property p_idle; flash_busy == cpu_idle_req; endproperty
	a_idle: assert property (p_idle) else $error("idle request differs from busy");
	property p_busy_min; s_busy_end |-> busy_cnt_ff >= 32'h100; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy shorter than erase plus program");
	property p_busy_max; flash_busy |-> busy_cnt_ff <= PROG_CYCLES + 4; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy not cleared in time");
	property p_launch; $rose(flash_busy) |-> s_axi_bvalid; endproperty
	a_launch: assert property (p_launch) else $error("busy without a register write");
	property p_fwd; int_ram_wr || ext_ram_wr |-> $past(dwr_valid) && ram_wr_addr == $past(dwr_addr); endproperty
	a_fwd: assert property (p_fwd) else $error("forwarded write without cause");
	property p_excl; !(int_ram_wr && ext_ram_wr); endproperty
	a_excl: assert property (p_excl) else $error("write sent to both memories");
	property p_boot; code_rd_boot |-> code_rd_valid && $past(code_rd_addr) >= 16'hf800; endproperty
	a_boot: assert property (p_boot) else $error("boot flag outside boot window");
endmodule
`default_nettype wire

// File: verif/fplc_cpu_model.sv
// Core-side model: data-space writes and code reads
`timescale 1ns/1ps
`default_nettype none
module fplc_cpu_model
(
	input wire logic	aclk,
	output logic		dwr_valid,
	output logic [15:0]	dwr_addr,
	output logic [7:0]	dwr_data,
	output logic		code_rd_req,
	output logic [15:0]	code_rd_addr,
	input wire logic	int_ram_wr,
	input wire logic	ext_ram_wr,
	input wire logic	code_rd_valid,
	input wire logic [7:0]	code_rd_data,
	input wire logic	code_rd_boot
);
	// Interrupts are never raised here, so idle is left only by the block
	initial
	begin
		dwr_valid = 1'b0;
		dwr_addr = 16'h0;
		dwr_data = 8'h0;
		code_rd_req = 1'b0;
		code_rd_addr = 16'h0;
	end

	// Bus shows inverted leftovers after a write so stale values cannot pass
	task automatic dwr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] fwd);
		@(posedge aclk);
		dwr_valid <= 1'b1;
		dwr_addr <= a;
		dwr_data <= d;
		@(posedge aclk);
		dwr_valid <= 1'b0;
		dwr_addr <= ~a;
		dwr_data <= ~d;
		#1 fwd = {ext_ram_wr, int_ram_wr};
	endtask

	task automatic crd(input logic [15:0] a, output logic [9:0] r);
		@(posedge aclk);
		code_rd_req <= 1'b1;
		code_rd_addr <= a;
		@(posedge aclk);
		code_rd_req <= 1'b0;
		code_rd_addr <= ~a;
		#1 r = {code_rd_boot, code_rd_valid, code_rd_data};
	endtask
endmodule
`default_nettype wire

// File: verif/test_flash_program_launch_ctrl.sv
// Register-level tests of the flash program launch controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_launch_ctrl;
	localparam int PC = 300;
	logic		aclk, aresetn, awv, wv, bv, br, arv, arr, aw_r, w_r, rv, rr;
	logic		dv, crq, irw, erw, crv, crb, idle, busy;
	logic [3:0]	awa, ara;
	logic [31:0]	wd, rd, r;
	logic [1:0]	bresp, rresp, f;
	logic [9:0]	c;
	logic [15:0]	da, ca, rwa;
	logic [7:0]	dd, cd, rwd;
	int		miscompares, n_checks, n;

	fplc_flash_program_launch_ctrl #(.PROG_CYCLES(PC)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(w_r), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .dwr_valid(dv),
		.dwr_addr(da), .dwr_data(dd), .int_ram_wr(irw), .ext_ram_wr(erw), .ram_wr_addr(rwa),
		.ram_wr_data(rwd), .code_rd_req(crq), .code_rd_addr(ca), .code_rd_valid(crv),
		.code_rd_data(cd), .code_rd_boot(crb), .cpu_idle_req(idle), .flash_busy(busy));
	fplc_cpu_model cpu (.aclk(aclk), .dwr_valid(dv), .dwr_addr(da), .dwr_data(dd), .code_rd_req(crq),
		.code_rd_addr(ca), .int_ram_wr(irw), .ext_ram_wr(erw), .code_rd_valid(crv),
		.code_rd_data(cd), .code_rd_boot(crb));

	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic results;
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (aw_r) awv <= 1'b0;
			if (w_r) wv <= 1'b0;
		end
		while (!bv);
		br <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a);
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end
		while (!rv);
		r = rd;
		f = rresp;
		rr <= 1'b0;
	endtask

	// Write k, then k with its key nibble inverted (key 5 becomes A); the busy window is then waited out
	task automatic prog(input logic [7:0] k);
		axw(fplc_pkg::ADDR_CTRL, {24'h0, k});
		axw(fplc_pkg::ADDR_CTRL, {24'h0, k ^ 8'hf0});
		axr(fplc_pkg::ADDR_CTRL);
		chk(32'(r[0]), 32'h1);
		n = 0;
		while (busy && n < 2 * PC)
		begin
			@(posedge aclk);
			n++;
		end
		chk(32'({busy, idle}), 32'h0);
	endtask

	initial
	begin
		{aresetn, awv, wv, br, arv, rr} = 6'h0;
		{awa, ara, wd} = 40'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(fplc_pkg::ADDR_CTRL);
		chk(r, 32'h0);
		axr(4'h2);
		chk(32'(f), 32'(fplc_pkg::RESP_DECERR));
		chk(r, 32'h0);
		axw(fplc_pkg::ADDR_CTRL, 32'h08);
		cpu.dwr(16'h0105, 8'ha5, f);
		chk(32'(f), 32'h0);
		axw(fplc_pkg::ADDR_AUX, 32'h2);
		chk(32'(bresp), 32'(fplc_pkg::RESP_OKAY));
		cpu.dwr(16'h0183, 8'h3c, f);
		chk(32'(f), 32'h0);
		axr(fplc_pkg::ADDR_STATUS);
		chk(r, 32'h03);
		axw(fplc_pkg::ADDR_CTRL, 32'h58);
		axr(fplc_pkg::ADDR_STATUS);
		chk(r, 32'h103);
		axw(fplc_pkg::ADDR_CTRL, 32'h08);
		axw(fplc_pkg::ADDR_CTRL, 32'ha8);
		axw(fplc_pkg::ADDR_CTRL, 32'h5e);
		axw(fplc_pkg::ADDR_CTRL, 32'hae);
		repeat (3) @(posedge aclk);
		chk(32'(busy), 32'h0);
		axw(fplc_pkg::ADDR_CTRL, 32'h00);
		cpu.dwr(16'h0183, 8'h11, f);
		chk(32'(f), 32'h2);
		axw(fplc_pkg::ADDR_AUX, 32'h0);
		cpu.dwr(16'h0183, 8'h11, f);
		chk(32'(f), 32'h1);
		chk(32'({rwa, rwd}), 32'h018311);
		axw(fplc_pkg::ADDR_CTRL, 32'h58);
		axw(fplc_pkg::ADDR_CTRL, 32'ha8);
		axw(fplc_pkg::ADDR_CTRL, 32'h08);
		axr(fplc_pkg::ADDR_CTRL);
		chk(32'(r[0]), 32'h1);
		cpu.crd(16'h0185, c);
		chk(32'({c[8], idle}), 32'h1);
		prog(8'h08);
		axw(fplc_pkg::ADDR_CTRL, 32'h08);
		cpu.dwr(16'h0184, 8'h77, f);
		prog(8'h58);
		axw(fplc_pkg::ADDR_CTRL, 32'h00);
		cpu.crd(16'h0185, c);
		chk(32'(c), 32'h1a5);
		cpu.crd(16'h0183, c);
		chk(32'(c), 32'h13c);
		cpu.crd(16'h0184, c);
		chk(32'(c), 32'h177);
		axw(fplc_pkg::ADDR_CTRL, 32'h0a);
		cpu.dwr(16'hff81, 8'h5a, f);
		prog(8'h5a);
		axw(fplc_pkg::ADDR_CTRL, 32'h02);
		cpu.crd(16'hff81, c);
		chk(32'(c), 32'h15a);
		axw(fplc_pkg::ADDR_CTRL, 32'h0c);
		cpu.dwr(16'h0000, 8'hc3, f);
		prog(8'h5c);
		axw(fplc_pkg::ADDR_CTRL, 32'h04);
		cpu.crd(16'h0000, c);
		chk(32'(c), 32'h1c3);
		cpu.crd(16'h0001, c);
		chk(32'(c), 32'h1ff);
		axw(fplc_pkg::ADDR_CTRL, 32'h00);
		axw(fplc_pkg::ADDR_AUX_ONE, 32'h20);
		cpu.crd(16'hf800, c);
		chk(32'(c[9]), 32'h1);
		cpu.crd(16'hf7ff, c);
		chk(32'(c[9]), 32'h0);
		results;
	end

	initial
	begin
		#60000;
		miscompares++;
		results;
	end
endmodule

bind fplc_flash_program_launch_ctrl fplc_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .dwr_valid(dwr_valid), .dwr_addr(dwr_addr), .int_ram_wr(int_ram_wr),
	.ext_ram_wr(ext_ram_wr), .ram_wr_addr(ram_wr_addr), .code_rd_req(code_rd_req), .code_rd_addr(code_rd_addr),
	.code_rd_valid(code_rd_valid), .code_rd_boot(code_rd_boot), .cpu_idle_req(cpu_idle_req),
	.flash_busy(flash_busy));
`default_nettype wire
